// ### dv/sc_card_model.sv
// card model: sends characters, collects and refuses returned ones
// assumes a pulled-up line, even parity and ref clock bit timing
`timescale 1ns/100ps
module sc_card_model #(
  parameter int BIT = 744
) (
  input wire logic clk_i,
  input wire logic dev_o_i,
  input wire logic dev_oe_i,
  output logic line_o
);
  logic card_low = 1'b0;
  logic busy = 1'b0;
  logic nak = 1'b0;
  logic [8:0] sh;
  logic [9:0] fr;
  int naks = 0;
  logic [8:0] got[$];
  // ==========
  // wired line with pull-up
  assign line_o = !(card_low || (dev_oe_i && !dev_o_i));
  task automatic send(input logic [7:0] d, input logic bad);
    fr = {(^d) ^ bad, d, 1'b0};
    busy = 1'b1;
    for (int i = 0; i < 10; i++) begin
      card_low <= !fr[i];
      repeat (BIT) @(posedge clk_i);
    end
    card_low <= 1'b0;
    repeat (BIT / 2) @(posedge clk_i);
    nak = !line_o;
    repeat (BIT + BIT / 2) @(posedge clk_i);
    busy = 1'b0;
  endtask
  // collect device frames, refuse on command
  initial forever begin
    @(negedge line_o);
    if (!busy) begin
      repeat (BIT / 2) @(posedge clk_i);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT) @(posedge clk_i);
        sh = {line_o, sh[8:1]};
      end
      got.push_back(sh);
      repeat (BIT / 2) @(posedge clk_i);
      if (naks > 0) begin
        naks--;
        card_low <= 1'b1;
        repeat (BIT) @(posedge clk_i);
        card_low <= 1'b0;
      end
    end
  end
endmodule // sc_card_model

// ### dv/sc_serial_chk_sva.sv
// port checker for the smart card serial unit
// assumes it is bound onto smart_card_serial_retransmit
`timescale 1ns/100ps
module sc_serial_chk #(
  parameter int DIV_W = 16,
  parameter logic [DIV_W-1:0] BASE_DIV = 1
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic data_oe_o,
  input wire logic comm_error_interrupt_o,
  input wire logic receive_full_interrupt_o,
  input wire logic transmit_empty_interrupt_o,
  input wire sc_pkg::sc_flags_s flags_o
);
  import sc_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  localparam int FRAME = 10 * 372 * (int'(BASE_DIV) + 1);
  // ==========
  // length of one drive stretch
  int oe_cnt;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      oe_cnt <= 0;
    else
      oe_cnt <= data_oe_o ? oe_cnt + 1 : 0;
  end
  sequence err_back;
    $rose(flags_o.ers);
  endsequence
  // the retry starts two cycles after guard_end, in the same cycle as the flag rises
  sequence resend;
    ##[0:2] $rose(data_oe_o);
  endsequence
  bus_answer_a:
    assert property ($rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o) else $error("late answer");
  err_irq_src_a:
    assert property (comm_error_interrupt_o |-> (flags_o.perr || flags_o.ers || flags_o.ovr
      || $past(flags_o.perr || flags_o.ers || flags_o.ovr))) else $error("error irq without flag");
  rx_irq_src_a:
    assert property (receive_full_interrupt_o |-> flags_o.rx_full || $past(flags_o.rx_full))
      else $error("rx irq without flag");
  tx_irq_src_a:
    assert property (transmit_empty_interrupt_o |-> flags_o.tx_end || $past(flags_o.tx_end))
      else $error("tx irq without flag");
  rx_clean_a:
    assert property (!($rose(flags_o.rx_full) && $rose(flags_o.perr))) else $error("full with parity error");
  tx_clean_a:
    assert property (!($rose(flags_o.tx_end) && $rose(flags_o.ers))) else $error("end with error signal");
  frame_len_a:
    assert property (oe_cnt <= FRAME) else $error("drive too long");
  retransmit_a:
    assert property (err_back |-> resend) else $error("no retransmission");
endmodule // sc_serial_chk

// ### dv/smart_card_serial_retransmit_tb_top.sv
// self-checking bench for the smart card serial unit
// assumes the checker and card model are compiled first
`timescale 1ns/100ps
`include "sc_defs.svh"
module smart_card_serial_retransmit_tb_top;
  import sc_pkg::*;
  `define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
  logic ref_clk_i, arst_n_i, avs_read_i, avs_write_i, data_i, data_o, data_oe_o;
  logic avs_waitrequest_o, ce_irq, rx_irq, tx_irq;
  logic [3:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [7:0] b, e;
  sc_flags_s flags_o;
  int errors, comparisons, cyc;
  int exp_q[$];
  smart_card_serial_retransmit #(.BASE_DIV(16'h0001)) uut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o),
    .comm_error_interrupt_o(ce_irq), .receive_full_interrupt_o(rx_irq),
    .transmit_empty_interrupt_o(tx_irq), .flags_o(flags_o));
  sc_card_model #(.BIT(744)) card (.clk_i(ref_clk_i), .dev_o_i(data_o), .dev_oe_i(data_oe_o), .line_o(data_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  task automatic wrap_up;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= d;
    do begin
      @(posedge ref_clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic wait_flag(input int i);
    int n;
    n = 0;
    while (flags_o[i] !== 1'b1 && n < 20000) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n == 20000)
      errors++;
    repeat (3) @(posedge ref_clk_i);
  endtask
  initial begin
    {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i, arst_n_i} = '0;
    repeat (4) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    void'($urandom(32'h219E));
    `CHK(flags_o, `SC_STAT_RST)
    acc(1'b0, `SC_STAT_OFS, 32'h0);
    `CHK(q[4:0], `SC_STAT_RST)
    acc(1'b0, 4'h2, 32'h0);
    `CHK(q, 32'h0)
    acc(1'b1, `SC_CTRL_OFS, 32'h0E);
    b = 8'($urandom);
    exp_q.push_back(b);
    card.send(b, 1'b0);
    wait_flag(`SC_ST_RECEIVE_FULL_FLAG);
    `CHK({flags_o.perr, ce_irq, rx_irq, card.nak}, 4'b0010)
    acc(1'b0, `SC_RXD_OFS, 32'h0);
    e = 8'(exp_q.pop_front());
    `CHK(q[7:0], e)
    acc(1'b1, `SC_STAT_OFS, 32'hF7);
    b = 8'($urandom);
    exp_q.push_back(b);
    card.send(b, 1'b1);
    `CHK({flags_o.perr, flags_o.rx_full, ce_irq, card.nak}, 4'b1011)
    acc(1'b1, `SC_CTRL_OFS, 32'h06);
    repeat (3) @(posedge ref_clk_i);
    `CHK(ce_irq, 1'b0)
    acc(1'b1, `SC_CTRL_OFS, 32'h0E);
    acc(1'b1, `SC_STAT_OFS, 32'hFE);
    card.send(b, 1'b0);
    wait_flag(`SC_ST_RECEIVE_FULL_FLAG);
    `CHK({flags_o.perr, flags_o.rx_full, card.nak}, 3'b010)
    acc(1'b0, `SC_RXD_OFS, 32'h0);
    e = 8'(exp_q.pop_front());
    `CHK(q[7:0], e)
    acc(1'b1, `SC_CTRL_OFS, 32'h1E);
    b = 8'($urandom);
    exp_q.push_back(b);
    card.send(b, 1'b1);
    wait_flag(`SC_ST_RECEIVE_FULL_FLAG);
    `CHK({flags_o.perr, flags_o.ovr, flags_o.rx_full, ce_irq, card.nak}, 5'b01110)
    acc(1'b0, `SC_RXD_OFS, 32'h0);
    e = 8'(exp_q.pop_front());
    `CHK(q[7:0], e)
    acc(1'b1, `SC_STAT_OFS, 32'hF3);
    acc(1'b1, `SC_CTRL_OFS, 32'h0D);
    card.naks = 1;
    b = 8'($urandom);
    acc(1'b1, `SC_TXD_OFS, {24'h0, b});
    repeat (2) @(posedge ref_clk_i);
    `CHK(flags_o.tx_end, 1'b0)
    wait_flag(`SC_ST_ERS);
    `CHK({flags_o.tx_end, ce_irq}, 2'b01)
    acc(1'b1, `SC_STAT_OFS, 32'hFD);
    wait_flag(`SC_ST_TRANSMIT_END_FLAG);
    `CHK({flags_o.ers, tx_irq, card.got.size() == 2}, 3'b011)
    foreach (card.got[i]) `CHK(card.got[i], {^b, b})
    wrap_up();
  end
endmodule // smart_card_serial_retransmit_tb_top
bind smart_card_serial_retransmit sc_serial_chk #(.DIV_W(DIV_W), .BASE_DIV(BASE_DIV)) chk (
  .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .data_oe_o(data_oe_o), .comm_error_interrupt_o(comm_error_interrupt_o),
  .receive_full_interrupt_o(receive_full_interrupt_o), .transmit_empty_interrupt_o(transmit_empty_interrupt_o),
  .flags_o(flags_o));

// ### rtl/sc_base_gen.sv
// base clock tick generator: one tick per base clock cycle
// assumes a divisor of one or more reference clock cycles
`timescale 1ns/100ps
module sc_base_gen #(
  parameter int DIV_W = 16
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic [DIV_W-1:0] div_i,
  output logic tick_o
);
  logic [DIV_W-1:0] cnt_reg;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_reg <= '0;
      tick_o <= 1'b0;
    end else if (cnt_reg >= div_i) begin
      cnt_reg <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      tick_o <= 1'b0;
    end
  end
endmodule // sc_base_gen

// ### rtl/sc_defs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit avalon-mm slave with byte addressing
`ifndef SC_DEFS_SVH
`define SC_DEFS_SVH
// ==========================================================
// register byte offsets
`define SC_CTRL_OFS 4'h0
`define SC_STAT_OFS 4'h4
`define SC_TXD_OFS 4'h8
`define SC_RXD_OFS 4'hC
// ==========================================================
// control register fields
`define SC_CTRL_TE 0
`define SC_CTRL_RE 1
`define SC_CTRL_TIE 2
`define SC_CTRL_RIE 3
`define SC_CTRL_ODD 4
`define SC_CTRL_RST 5'h00
// ==========================================================
// status register fields
`define SC_ST_PER 0
`define SC_ST_ERS 1
`define SC_ST_OVERRUN_FLAG 2
`define SC_ST_RECEIVE_FULL_FLAG 3
`define SC_ST_TRANSMIT_END_FLAG 4
`define SC_STAT_RST 5'h10
// ==========================================================
// bit timing, in base clock cycles and in bits
`define SC_BASE_PER_BIT 372
`define SC_SAMPLE_AT 186
`define SC_FRAME_BITS 10
`define SC_GUARD_BITS 2
`endif

// ### rtl/sc_pkg.sv
// types shared by the smart card serial block
// constants live in sc_defs.svh
package sc_pkg;
  typedef struct packed {
    logic [7:0] data;
    logic odd;
  } sc_char_s;
  typedef struct packed {
    logic tx_end;
    logic rx_full;
    logic ovr;
    logic ers;
    logic perr;
  } sc_flags_s;
endpackage

// ### rtl/sc_sync.sv
// two flip-flop synchroniser for a pin level
// assumes the input is asynchronous to ref_clk_i
`timescale 1ns/100ps
module sc_sync (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_reg;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_reg <= 1'b1;
      q_o <= 1'b1;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule // sc_sync

// ### rtl/smart_card_serial_retransmit.sv
// smart card half-duplex serial unit with parity retransmission
// assumes an avalon-mm master on ref_clk_i and a pulled-up data line
//
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
`include "sc_defs.svh"
module smart_card_serial_retransmit #(
  parameter int DIV_W = 16,
  parameter logic [DIV_W-1:0] BASE_DIV = 1
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic data_i,
  output logic data_o,
  output logic data_oe_o,
  output logic comm_error_interrupt_o,
  output logic receive_full_interrupt_o,
  output logic transmit_empty_interrupt_o,
  output sc_pkg::sc_flags_s flags_o
);
  import sc_pkg::*;

  // ==========================================================
  // elaboration checks
  if (DIV_W < 1 || BASE_DIV == '0) begin : g_bad_div
    $error("bad base divider");
  end
  if (`SC_SAMPLE_AT >= `SC_BASE_PER_BIT || `SC_BASE_PER_BIT > 512) begin : g_bad_bit
    $error("bit timing does not fit the nine bit counter");
  end
  if (`SC_FRAME_BITS + `SC_GUARD_BITS > 16) begin : g_bad_frame
    $error("frame does not fit the four bit counter");
  end

  localparam logic [8:0] BIT_LAST = 9'(`SC_BASE_PER_BIT - 1);
  localparam logic [8:0] SAMPLE_CNT = 9'(`SC_SAMPLE_AT - 1);
  localparam logic [3:0] PAR_BIT = 4'(`SC_FRAME_BITS - 1);
  localparam logic [3:0] GUARD_END = 4'(`SC_FRAME_BITS + `SC_GUARD_BITS - 1);

  typedef enum {S_IDLE, S_RX, S_TX} mode_e;

  // ==========================================================
  // base clock and pin synchroniser
  logic tick;
  logic line;
  sc_base_gen #(.DIV_W(DIV_W)) u_base (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .div_i(BASE_DIV),
    .tick_o(tick)
  );
  sc_sync u_sync (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .d_i(data_i),
    .q_o(line)
  );

  // ==========================================================
  // registers
  logic [4:0] ctrl_reg;
  sc_flags_s flags_reg;
  sc_char_s tx_reg;
  logic [7:0] rx_data_reg;
  logic ack_reg;
  logic wr_go, rd_go;
  logic wr_ctrl, wr_txd;
  // writes land in the cycle that shows waitrequest low
  assign wr_go = avs_write_i && ack_reg;
  // read data fetched a cycle early so it stands when waitrequest drops
  assign rd_go = avs_read_i && !ack_reg;
  assign wr_ctrl = wr_go && avs_address_i == `SC_CTRL_OFS && avs_byteenable_i[0];
  assign wr_txd = wr_go && avs_address_i == `SC_TXD_OFS && avs_byteenable_i[0];

  // ==========================================================
  // frame engine
  mode_e mode_reg;
  logic [8:0] bcnt_reg;
  logic [3:0] bit_reg;
  logic [8:0] shift_reg;
  logic line_d_reg;
  logic err_reg;
  logic tx_pend_reg;
  logic bit_end, sample;
  logic rx_par_ok;
  logic ev_perr, ev_rxok, ev_ers, ev_txok, ev_ovr;
  logic par_end, guard_end;
  assign bit_end = tick && (bcnt_reg == BIT_LAST);
  assign sample = tick && (bcnt_reg == SAMPLE_CNT);
  assign par_end = bit_end && bit_reg == PAR_BIT;
  assign guard_end = bit_end && bit_reg == GUARD_END;
  // shift_reg[8] is the parity bit once all nine are in
  assign rx_par_ok = ((^shift_reg) ^ ctrl_reg[`SC_CTRL_ODD]) == 1'b0;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      line_d_reg <= 1'b1;
    end else begin
      line_d_reg <= line;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_reg <= S_IDLE;
      bcnt_reg <= '0;
      bit_reg <= '0;
      shift_reg <= '0;
      err_reg <= 1'b0;
      data_o <= 1'b1;
      data_oe_o <= 1'b0;
    end else begin
      unique case (mode_reg)
        S_IDLE: begin
          data_oe_o <= 1'b0;
          bcnt_reg <= '0;
          bit_reg <= '0;
          err_reg <= 1'b0;
          // a pending character goes first when both directions are on
          if (ctrl_reg[`SC_CTRL_TE] && tx_pend_reg) begin
            mode_reg <= S_TX;
            shift_reg <= {(^tx_reg.data) ^ tx_reg.odd, tx_reg.data};
            data_o <= 1'b0;
            data_oe_o <= 1'b1;
          end else if (ctrl_reg[`SC_CTRL_RE] && line_d_reg && !line) begin
            mode_reg <= S_RX;
          end
        end
        S_RX: begin
          if (tick) begin
            bcnt_reg <= bit_end ? 9'h000 : bcnt_reg + 9'h001;
          end
          if (sample && bit_reg >= 4'h1 && bit_reg <= PAR_BIT) begin
            shift_reg <= {line, shift_reg[8:1]};
          end
          if (bit_end) begin
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg == PAR_BIT && !rx_par_ok) begin
              data_o <= 1'b0;
              data_oe_o <= 1'b1;
            end else begin
              data_oe_o <= 1'b0;
            end
            if (bit_reg == PAR_BIT + 4'h1) begin
              data_oe_o <= 1'b0;
            end
            if (bit_reg == GUARD_END) begin
              mode_reg <= S_IDLE;
            end
          end
        end
        S_TX: begin
          if (tick) begin
            bcnt_reg <= bit_end ? 9'h000 : bcnt_reg + 9'h001;
          end
          if (sample && bit_reg == PAR_BIT + 4'h1 && !line) begin
            err_reg <= 1'b1;
          end
          if (bit_end) begin
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg < PAR_BIT) begin
              data_o <= shift_reg[0];
              shift_reg <= {1'b1, shift_reg[8:1]};
              data_oe_o <= 1'b1;
            end else begin
              data_o <= 1'b1;
              data_oe_o <= 1'b0;
            end
            if (bit_reg == GUARD_END) begin
              mode_reg <= S_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign ev_perr = (mode_reg == S_RX) && par_end && !rx_par_ok;
  assign ev_rxok = (mode_reg == S_RX) && par_end && rx_par_ok;
  assign ev_ovr = ev_rxok && flags_reg.rx_full;
  assign ev_ers = (mode_reg == S_TX) && guard_end && err_reg;
  assign ev_txok = (mode_reg == S_TX) && guard_end && !err_reg;

  // ==========================================================
  // transmit holding: kept after an error signal for retransmit
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_reg <= '0;
      tx_pend_reg <= 1'b0;
    end else if (wr_txd) begin
      tx_reg.data <= avs_writedata_i[7:0];
      // parity sense frozen with the character for its retransmissions
      tx_reg.odd <= ctrl_reg[`SC_CTRL_ODD];
      tx_pend_reg <= 1'b1;
    end else if (ev_txok) begin
      tx_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_data_reg <= '0;
    end else if (mode_reg == S_RX && par_end) begin
      rx_data_reg <= shift_reg[7:0];
    end
  end

  // ==========================================================
  // control register
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_reg <= `SC_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= avs_writedata_i[4:0];
    end
  end

  // ==========================================================
  // status flags: write 0 clears all but tx_end (cleared by a transmit data write), hardware set wins
  logic st_wr;
  logic [4:0] clr;
  assign st_wr = wr_go && avs_address_i == `SC_STAT_OFS && avs_byteenable_i[0];
  assign clr = st_wr ? ~avs_writedata_i[4:0] : 5'h00;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flags_reg <= `SC_STAT_RST;
    end else begin
      flags_reg.perr <= ev_perr | (flags_reg.perr & ~clr[`SC_ST_PER]);
      flags_reg.ers <= ev_ers | (flags_reg.ers & ~clr[`SC_ST_ERS]);
      flags_reg.ovr <= ev_ovr | (flags_reg.ovr & ~clr[`SC_ST_OVERRUN_FLAG]);
      flags_reg.rx_full <= ev_rxok | (flags_reg.rx_full & ~clr[`SC_ST_RECEIVE_FULL_FLAG]);
      if (ev_txok) begin
        flags_reg.tx_end <= 1'b1;
      end else if (wr_txd) begin
        flags_reg.tx_end <= 1'b0;
      end
    end
  end

  // ==========================================================
  // interrupts: transmit end drives transmit_empty_interrupt_o
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      comm_error_interrupt_o <= 1'b0;
      receive_full_interrupt_o <= 1'b0;
      transmit_empty_interrupt_o <= 1'b0;
      flags_o <= `SC_STAT_RST;
    end else begin
      comm_error_interrupt_o <= ctrl_reg[`SC_CTRL_RIE] &
        (flags_reg.perr | flags_reg.ers | flags_reg.ovr);
      receive_full_interrupt_o <= ctrl_reg[`SC_CTRL_RIE] & flags_reg.rx_full;
      transmit_empty_interrupt_o <= ctrl_reg[`SC_CTRL_TIE] & flags_reg.tx_end;
      flags_o <= flags_reg;
    end
  end

  // ==========================================================
  // avalon slave: one wait cycle per access
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_reg <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= '0;
    end else begin
      ack_reg <= (avs_read_i || avs_write_i) && !ack_reg;
      // registered inverse of the next ack_reg
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack_reg);
      if (rd_go) begin
        unique case (avs_address_i)
          `SC_CTRL_OFS: avs_readdata_o <= {27'h0, ctrl_reg};
          `SC_STAT_OFS: avs_readdata_o <= {27'h0, flags_reg};
          `SC_TXD_OFS: avs_readdata_o <= {24'h0, tx_reg.data};
          `SC_RXD_OFS: avs_readdata_o <= {24'h0, rx_data_reg};
          default: avs_readdata_o <= 32'h0;
        endcase
      end
    end
  end
endmodule // smart_card_serial_retransmit
